// file: logic/rom_id_pkg.sv
// constants, carrier types and check-code helpers for the identity and access gate
// assumes one 200 MHz system clock shared by every user of this package
package rom_id_pkg;
  // identity code layout
  localparam int FAM_W  = 8;
  localparam int SER_W  = 48;
  localparam int CRC_W  = 8;
  localparam int BODY_W = FAM_W + SER_W;
  localparam int ROM_W  = BODY_W + CRC_W;
  localparam int CNT_W  = 6;
  // x^8 + x^5 + x^4 + 1, taps seen from a right-shifting register
  localparam logic [CRC_W-1:0] CRC_POLY_REFL = 8'h8C;
  localparam logic [CRC_W-1:0] CRC_ZERO      = 8'h00;
  // identity defaults: arbitrary values, not any real part
  localparam logic [FAM_W-1:0] FAMILY_DEF    = 8'h5A;
  localparam logic [SER_W-1:0] SERIAL_DEF    = 48'h0123456789AB;
  // add-only data memory
  localparam int MEM_BITS  = 1024;
  localparam int PAGES     = 4;
  localparam int PAGE_BITS = 256;
  localparam int BYTE_W    = 8;
  localparam int MEM_BYTES = MEM_BITS / BYTE_W;
  localparam int ADDR_W    = 7;
  localparam int PAGE_W    = 2;
  localparam int PAGE_LSB  = ADDR_W - PAGE_W;
  localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hFF;
  // memory function command codes; the last three are arbitrary
  localparam logic [7:0] CMD_READ_MEM    = 8'hF0;
  localparam logic [7:0] CMD_READ_STATUS = 8'hAA;
  localparam logic [7:0] CMD_READ_CRC    = 8'h11;
  localparam logic [7:0] CMD_PROG_MEM    = 8'h22;
  localparam logic [7:0] CMD_PROG_STATUS = 8'h33;

  typedef enum logic {INIT_SHIFT, INIT_DONE} init_state_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } prog_req_t;

  function automatic logic [CRC_W-1:0] crc8_step(input logic [CRC_W-1:0] crc, input logic b);
    logic fb;
    fb = crc[0] ^ b;
    crc8_step = (crc >> 1) ^ (fb ? CRC_POLY_REFL : CRC_ZERO);
  endfunction

  function automatic logic [CRC_W-1:0] crc8_residue(input logic [ROM_W-1:0] code);
    logic [CRC_W-1:0] c;
    c = CRC_ZERO;
    for (int i = 0; i < ROM_W; i++) begin
      c = crc8_step(c, code[i]);
    end
    crc8_residue = c;
  endfunction
endpackage

// file: logic/rom_id_crc_access_gate.sv
// identity code with self-computed check byte, streaming check-code unit,
// memory-command gate and add-only byte memory with page write protection
// assumes bit-slot decoding and command parsing sit outside on the same clock;
// only the programming-voltage detect arrives asynchronously
`timescale 1ns/1ps

//Contract
// - hold 64-bit code: family, serial, check
// - check byte uses x^8+x^5+x^4+1
// - accumulator cleared before first bit
// - shift family then serial, LSB first
// - shifting check byte leaves zero residue
// - refuse memory commands before ROM success
// - after ROM success accept five commands
// - all bus data sent LSB first
// - programming only clears bits, never sets
// - programming qualified by detected programming voltage
// - four 256-bit pages, each write-protectable
module rom_id_crc_access_gate #(
  parameter logic [rom_id_pkg::FAM_W-1:0] FAMILY = rom_id_pkg::FAMILY_DEF,
  parameter logic [rom_id_pkg::SER_W-1:0] SERIAL = rom_id_pkg::SERIAL_DEF
) (
  // clock and reset
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_rst,
  // identity code
  output logic                                o_rom_valid,
  output logic [rom_id_pkg::ROM_W-1:0]        o_rom_code,
  // identity transmit shifter
  input  wire logic                           i_tx_load,
  input  wire logic                           i_tx_next,
  output logic                                o_tx_bit,
  // received-code checker
  input  wire logic                           i_chk_start,
  input  wire logic                           i_chk_valid,
  input  wire logic                           i_chk_bit,
  output logic [rom_id_pkg::CRC_W-1:0]        o_chk_crc,
  output logic                                o_chk_zero,
  // access gate
  input  wire logic                           i_rom_ok,
  input  wire logic                           i_bus_reset,
  input  wire logic                           i_cmd_valid,
  input  wire logic [7:0]                     i_cmd,
  output logic                                o_gate_open,
  output logic                                o_cmd_accept,
  output logic                                o_cmd_refuse,
  // programming
  input  wire logic                           i_pgm_voltage,
  input  wire rom_id_pkg::prog_req_t          i_prog,
  input  wire logic                           i_wp_valid,
  input  wire logic [rom_id_pkg::PAGE_W-1:0]  i_wp_page,
  output logic                                o_pgm_voltage_seen,
  output logic [rom_id_pkg::PAGES-1:0]        o_wp,
  // read port
  input  wire logic [rom_id_pkg::ADDR_W-1:0]  i_rd_addr,
  output logic [rom_id_pkg::BYTE_W-1:0]       o_rd_data
);

  // identity build: check byte computed once after reset from the lasered fields
  rom_id_pkg::init_state_t               init_st_q, init_st_d;
  logic [rom_id_pkg::BODY_W-1:0]         body_sh_q, body_sh_d;
  logic [rom_id_pkg::CNT_W-1:0]          init_cnt_q, init_cnt_d;
  logic [rom_id_pkg::CRC_W-1:0]          init_crc_q, init_crc_d;
  logic [rom_id_pkg::ROM_W-1:0]          rom_q, rom_d;
  logic                                  rom_valid_q, rom_valid_d;

  always_comb begin
    init_st_d   = init_st_q;
    body_sh_d   = body_sh_q;
    init_cnt_d  = init_cnt_q;
    init_crc_d  = init_crc_q;
    rom_d       = rom_q;
    rom_valid_d = rom_valid_q;
    case (init_st_q)
      rom_id_pkg::INIT_SHIFT: begin
        init_crc_d = rom_id_pkg::crc8_step(init_crc_q, body_sh_q[0]);
        body_sh_d  = body_sh_q >> 1;
        init_cnt_d = init_cnt_q + 1'b1;
        if (init_cnt_q == rom_id_pkg::CNT_W'(rom_id_pkg::BODY_W - 1)) begin
          rom_d       = {rom_id_pkg::crc8_step(init_crc_q, body_sh_q[0]),
                         SERIAL, FAMILY};
          rom_valid_d = 1'b1;
          init_st_d   = rom_id_pkg::INIT_DONE;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      init_st_q   <= rom_id_pkg::INIT_SHIFT;
      body_sh_q   <= {SERIAL, FAMILY};
      init_cnt_q  <= '0;
      init_crc_q  <= rom_id_pkg::CRC_ZERO;
      rom_q       <= '0;
      rom_valid_q <= 1'b0;
    end else begin
      init_st_q   <= init_st_d;
      body_sh_q   <= body_sh_d;
      init_cnt_q  <= init_cnt_d;
      init_crc_q  <= init_crc_d;
      rom_q       <= rom_d;
      rom_valid_q <= rom_valid_d;
    end
  end

  // transmit shifter and received-code checker
  logic [rom_id_pkg::ROM_W-1:0] tx_sh_q, tx_sh_d;
  logic [rom_id_pkg::CRC_W-1:0] chk_q, chk_d;
  logic                         chk_zero_q, chk_zero_d;

  always_comb begin
    tx_sh_d = tx_sh_q;
    if (i_tx_load) begin
      tx_sh_d = rom_q;
    end else if (i_tx_next) begin
      tx_sh_d = tx_sh_q >> 1;
    end
    chk_d = chk_q;
    if (i_chk_start) begin
      chk_d = rom_id_pkg::CRC_ZERO;
    end else if (i_chk_valid) begin
      chk_d = rom_id_pkg::crc8_step(chk_q, i_chk_bit);
    end
    // flag kept in a flop so it leaves the block glitch-free, in step with the accumulator
    chk_zero_d = (chk_d == rom_id_pkg::CRC_ZERO);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_sh_q    <= '0;
      chk_q      <= rom_id_pkg::CRC_ZERO;
      chk_zero_q <= 1'b1;
    end else begin
      tx_sh_q    <= tx_sh_d;
      chk_q      <= chk_d;
      chk_zero_q <= chk_zero_d;
    end
  end

  // access gate: a ROM success in the same cycle as a bus reset keeps the gate open
  logic gate_q, gate_d;
  logic acc_q, acc_d;
  logic ref_q, ref_d;
  logic cmd_known;

  always_comb begin
    cmd_known = (i_cmd == rom_id_pkg::CMD_READ_MEM)    ||
                (i_cmd == rom_id_pkg::CMD_READ_STATUS) ||
                (i_cmd == rom_id_pkg::CMD_READ_CRC)    ||
                (i_cmd == rom_id_pkg::CMD_PROG_MEM)    ||
                (i_cmd == rom_id_pkg::CMD_PROG_STATUS);
    gate_d = gate_q;
    if (i_rom_ok && rom_valid_q) begin
      gate_d = 1'b1;
    end else if (i_bus_reset) begin
      gate_d = 1'b0;
    end
    acc_d = i_cmd_valid && gate_q && cmd_known;
    ref_d = i_cmd_valid && !(gate_q && cmd_known);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gate_q <= 1'b0;
      acc_q  <= 1'b0;
      ref_q  <= 1'b0;
    end else begin
      gate_q <= gate_d;
      acc_q  <= acc_d;
      ref_q  <= ref_d;
    end
  end

  // programming voltage detect: pin crosses in through two flops
  logic pv_meta_q, pv_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pv_meta_q <= 1'b0;
      pv_q      <= 1'b0;
    end else begin
      pv_meta_q <= i_pgm_voltage;
      pv_q      <= pv_meta_q;
    end
  end

  // add-only memory; requests without voltage or open gate are dropped silently
  logic [rom_id_pkg::BYTE_W-1:0] mem_q [rom_id_pkg::MEM_BYTES];
  logic [rom_id_pkg::BYTE_W-1:0] mem_d [rom_id_pkg::MEM_BYTES];
  logic [rom_id_pkg::PAGES-1:0]  wp_q, wp_d;
  logic [rom_id_pkg::BYTE_W-1:0] rd_q, rd_d;
  logic                          prog_ok;

  always_comb begin
    prog_ok = i_prog.valid && pv_q && gate_q &&
              !wp_q[i_prog.addr[rom_id_pkg::ADDR_W-1:rom_id_pkg::PAGE_LSB]];
    wp_d = wp_q;
    if (i_wp_valid && pv_q && gate_q) begin
      wp_d[i_wp_page] = 1'b1;
    end
    rd_d = mem_q[i_rd_addr];
  end

  for (genvar g = 0; g < rom_id_pkg::MEM_BYTES; g++) begin : g_byte
    always_comb begin
      mem_d[g] = mem_q[g];
      if (prog_ok && (i_prog.addr == rom_id_pkg::ADDR_W'(g))) begin
        mem_d[g] = mem_q[g] & i_prog.data;
      end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        mem_q[g] <= rom_id_pkg::ERASED_BYTE;
      end else begin
        mem_q[g] <= mem_d[g];
      end
    end

    chk_add_only: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (~$past(mem_q[g]) & mem_q[g]) == '0)
      else $error("memory bit went from zero to one");
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wp_q <= '0;
      rd_q <= rom_id_pkg::ERASED_BYTE;
    end else begin
      wp_q <= wp_d;
      rd_q <= rd_d;
    end
  end

  // outputs
  assign o_rom_valid        = rom_valid_q;
  assign o_rom_code         = rom_q;
  assign o_tx_bit           = tx_sh_q[0];
  assign o_chk_crc          = chk_q;
  assign o_chk_zero         = chk_zero_q;
  assign o_gate_open        = gate_q;
  assign o_cmd_accept       = acc_q;
  assign o_cmd_refuse       = ref_q;
  assign o_pgm_voltage_seen = pv_q;
  assign o_wp               = wp_q;
  assign o_rd_data          = rd_q;

  // checks
  chk_rom_fields: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    rom_valid_q |-> (rom_q[rom_id_pkg::BODY_W-1:0] == {SERIAL, FAMILY}))
    else $error("identity fields out of place");

  chk_rom_residue: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    rom_valid_q |-> (rom_id_pkg::crc8_residue(rom_q) == rom_id_pkg::CRC_ZERO))
    else $error("identity check byte wrong");

  chk_init_time: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(rom_valid_q) |-> ($past(init_cnt_q) == rom_id_pkg::CNT_W'(rom_id_pkg::BODY_W - 1)))
    else $error("check byte ready after wrong bit count");

  chk_clear_first: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_chk_start ##1 (!i_chk_start && i_chk_valid) |=> chk_q == rom_id_pkg::crc8_step(
      rom_id_pkg::CRC_ZERO, $past(i_chk_bit)))
    else $error("accumulator not cleared before first bit");

  chk_tx_lsb: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_tx_load ##1 (!i_tx_load && i_tx_next) |=> o_tx_bit == rom_q[1])
    else $error("identity not sent least significant bit first");

  chk_gate_refuse: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_cmd_valid && !gate_q) |=> (o_cmd_refuse && !o_cmd_accept))
    else $error("memory command taken before identity step");

  chk_gate_accept: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_cmd_valid && gate_q && i_cmd == rom_id_pkg::CMD_READ_MEM) |=> o_cmd_accept)
    else $error("memory command refused with gate open");

  chk_prog_voltage: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_prog.valid && !pv_q) |=> (mem_q[$past(i_prog.addr)] == $past(mem_q[i_prog.addr])))
    else $error("memory changed without programming voltage");

  chk_wp_blocks: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_prog.valid && wp_q[i_prog.addr[rom_id_pkg::ADDR_W-1:rom_id_pkg::PAGE_LSB]])
    |=> (mem_q[$past(i_prog.addr)] == $past(mem_q[i_prog.addr])))
    else $error("protected page altered");

  chk_gate_close: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_bus_reset && !(i_rom_ok && rom_valid_q)) |=> !o_gate_open)
    else $error("gate still open after bus reset");

  chk_wp_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ($past(wp_q) & ~wp_q) == '0)
    else $error("write protect bit cleared");

  cov_rom_ready: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(rom_valid_q));
  cov_accept:    cover property (@(posedge i_clk_sys) disable iff (i_rst) o_cmd_accept);
  cov_refuse:    cover property (@(posedge i_clk_sys) disable iff (i_rst) o_cmd_refuse);
  cov_program:   cover property (@(posedge i_clk_sys) disable iff (i_rst) prog_ok);
  cov_wp_set:    cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(|wp_q));

endmodule // rom_id_crc_access_gate

// file: tb/bus_master_model.sv
// far-side bus master: issues the ROM-function success pulse and the programming pulse
// assumes the bench raises each request for one cycle at a falling edge
`timescale 1ns/1ps
module bus_master_model #(
  parameter int PULSE = 12
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // requests from the bench
  input  wire logic i_rom_req,
  input  wire logic i_pulse_req,
  // towards the device
  output logic      o_rom_ok,
  output logic      o_pgm_voltage
);
  logic [7:0] cnt_q;
  // rom function sequence done only when the bench says so
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rom_ok <= 1'b0;
      cnt_q    <= 8'h00;
    end else begin
      o_rom_ok <= i_rom_req;
      if (i_pulse_req) cnt_q <= 8'(PULSE);
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
  end
  // brief high-voltage pulse after normal traffic; drops on its own
  assign o_pgm_voltage = (cnt_q != 8'h00);
endmodule // bus_master_model

// file: tb/tb.sv
// self-checking bench for the identity, check-code and access-gate block
// assumes inputs change at the falling edge and a 200 MHz system clock
`timescale 1ns/1ps
module tb;
  localparam logic [7:0]  FAM = 8'hC3;            // arbitrary
  localparam logic [47:0] SER = 48'h9E3779B97F4A; // arbitrary
  localparam logic [7:0]  CMDS [5] = '{rom_id_pkg::CMD_READ_MEM, rom_id_pkg::CMD_READ_STATUS,
    rom_id_pkg::CMD_READ_CRC, rom_id_pkg::CMD_PROG_MEM, rom_id_pkg::CMD_PROG_STATUS};
  logic clk, rst, tx_load, tx_next, chk_start, chk_valid, chk_bit, rom_ok, bus_reset;
  logic cmd_valid, pgm_v, wp_valid, rom_req, pulse_req, rom_valid, tx_bit, chk_zero;
  logic gate_open, cmd_accept, cmd_refuse, pv_seen;
  logic [7:0]  cmd, chk_crc, rd_data;
  logic [1:0]  wp_page;
  logic [3:0]  wp;
  logic [6:0]  rd_addr;
  logic [63:0] rom_code, exp_code;
  logic [31:0] seed;
  logic [7:0]  d1, d2;
  rom_id_pkg::prog_req_t prog;
  int errors, comparisons, cycles;
  rom_id_crc_access_gate #(.FAMILY(FAM), .SERIAL(SER)) dut (.i_clk_sys(clk), .i_rst(rst),
    .o_rom_valid(rom_valid), .o_rom_code(rom_code), .i_tx_load(tx_load), .i_tx_next(tx_next),
    .o_tx_bit(tx_bit), .i_chk_start(chk_start), .i_chk_valid(chk_valid), .i_chk_bit(chk_bit),
    .o_chk_crc(chk_crc), .o_chk_zero(chk_zero), .i_rom_ok(rom_ok), .i_bus_reset(bus_reset),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_gate_open(gate_open), .o_cmd_accept(cmd_accept),
    .o_cmd_refuse(cmd_refuse), .i_pgm_voltage(pgm_v), .i_prog(prog), .i_wp_valid(wp_valid),
    .i_wp_page(wp_page), .o_pgm_voltage_seen(pv_seen), .o_wp(wp), .i_rd_addr(rd_addr),
    .o_rd_data(rd_data));
  bus_master_model #(.PULSE(12)) master (.i_clk_sys(clk), .i_rst(rst), .i_rom_req(rom_req),
    .i_pulse_req(pulse_req), .o_rom_ok(rom_ok), .o_pgm_voltage(pgm_v));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // bench's own reflected x^8+x^5+x^4+1 register, cleared first, lsb first
  function automatic logic [7:0] crc_of(input logic [63:0] v, input int n);
    logic [7:0] c;
    logic f;
    c = 8'h00;
    for (int i = 0; i < n; i++) begin
      f = c[0] ^ v[i];
      c = c >> 1;
      if (f) c = c ^ 8'h8C;
    end
    return c;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic feed(input logic [63:0] v);
    chk_start = 1'b1;
    @(negedge clk) chk_start = 1'b0;
    for (int i = 0; i < 64; i++) begin
      chk_valid = 1'b1;
      chk_bit = v[i];
      @(negedge clk);
    end
    chk_valid = 1'b0;
  endtask
  task automatic send_cmd(input logic [7:0] c, input logic ok);
    cmd_valid = 1'b1;
    cmd = c;
    @(negedge clk) cmd_valid = 1'b0;
    chk({cmd_accept, cmd_refuse}, ok ? 2'b10 : 2'b01);
    @(negedge clk);
  endtask
  task automatic open_gate();
    rom_req = 1'b1;
    @(negedge clk) rom_req = 1'b0;
    @(negedge clk) chk(gate_open, 1'b1);
  endtask
  task automatic prog_byte(input logic [6:0] a, input logic [7:0] d);
    prog = '{valid: 1'b1, addr: a, data: d};
    @(negedge clk) prog.valid = 1'b0;
    @(negedge clk);
  endtask
  task automatic read_chk(input logic [6:0] a, input logic [7:0] e);
    rd_addr = a;
    @(negedge clk);
    @(negedge clk) chk(rd_data, e);
  endtask
  task automatic pulse();
    pulse_req = 1'b1;
    @(negedge clk) pulse_req = 1'b0;
    for (int i = 0; i < 10 && pv_seen !== 1'b1; i++) @(negedge clk);
    chk(pv_seen, 1'b1);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    {rst, tx_load, tx_next, chk_start, chk_valid, chk_bit, bus_reset} = 7'h40;
    {cmd_valid, wp_valid, rom_req, pulse_req} = 4'h0;
    {cmd, wp_page, rd_addr, prog} = 33'h0;
    seed = 32'h28945CBF;
    repeat (20) @(negedge clk);
    chk({rd_data, chk_zero, gate_open, wp}, {8'hFF, 1'b1, 1'b0, 4'h0});
    rst = 1'b0;
    exp_code = {8'h00, SER, FAM};
    exp_code[63:56] = crc_of(exp_code, 56);
    repeat (55) @(negedge clk);
    chk(rom_valid, 1'b0);
    @(negedge clk);
    chk(rom_valid, 1'b1);
    chk(rom_code, exp_code);
    tx_load = 1'b1;
    chk_start = 1'b1;
    @(negedge clk) {tx_load, chk_start} = 2'b00;
    for (int i = 0; i < 64; i++) begin
      chk(tx_bit, exp_code[i]);
      {tx_next, chk_valid, chk_bit} = {2'b11, tx_bit};
      @(negedge clk);
      if (i == 55) chk(chk_crc, exp_code[63:56]);
    end
    {tx_next, chk_valid} = 2'b00;
    chk(chk_zero, 1'b1);
    for (int r = 0; r < 4; r++) begin
      exp_code = {rnd(), rnd()};
      exp_code[63:56] = crc_of(exp_code, 56);
      feed(exp_code);
      chk(chk_zero, 1'b1);
      d1 = 8'(rnd());
      exp_code[d1[5:0]] ^= 1'b1;
      feed(exp_code);
      chk(chk_zero, 1'b0);
    end
    send_cmd(8'hF0, 1'b0);
    pulse();
    prog_byte(7'h21, 8'h00);
    read_chk(7'h21, 8'hFF);
    open_gate();
    foreach (CMDS[k]) send_cmd(CMDS[k], 1'b1);
    d1 = 8'(rnd());
    if (d1 inside {CMDS}) d1 = 8'h00;
    send_cmd(d1, 1'b0);
    bus_reset = 1'b1;
    @(negedge clk) bus_reset = 1'b0;
    chk(gate_open, 1'b0);
    send_cmd(8'hAA, 1'b0);
    open_gate();
    d1 = 8'(rnd());
    d2 = 8'(rnd());
    prog_byte(7'h20, d1); // earlier 12-cycle pulse has lapsed: dropped
    read_chk(7'h20, 8'hFF);
    pulse();
    prog_byte(7'h20, d1);
    prog_byte(7'h20, d2);
    wp_valid = 1'b1;
    wp_page = 2'h1;
    @(negedge clk) wp_valid = 1'b0;
    chk(wp, 4'h2);
    prog_byte(7'h40, d2);
    read_chk(7'h20, d1 & d2);
    read_chk(7'h40, d2);
    repeat (14) @(negedge clk);
    pulse();
    prog_byte(7'h3F, 8'h00);
    prog_byte(7'h1F, 8'h00);
    read_chk(7'h3F, 8'hFF);
    read_chk(7'h1F, 8'h00);
    test_done();
  end
endmodule // tb
